// ==== common/ang_pkg.sv ====
`default_nettype none
package ang_pkg;
   // Register byte addresses on the bus
   localparam logic [7:0] ADR_CTRL = 8'h80;
   localparam logic [7:0] ADR_STAT = 8'h84;
   localparam logic [7:0] ADR_ADV  = 8'h90;
   localparam logic [7:0] ADR_LPA  = 8'h94;
   localparam logic [7:0] ADR_EXP  = 8'h98;
   localparam logic [7:0] ADR_PHYS = 8'hC0;

   // Control register fields
   localparam int CTL_LOOP    = 14;
   localparam int CTL_SPEED   = 13;
   localparam int CTL_AN_EN   = 12;
   localparam int CTL_RESTART = 9;
   localparam int CTL_DUPLEX  = 8;
   localparam logic [15:0] CTL_WR_MASK = 16'h7100;
   localparam logic [15:0] CTL_RST     = 16'h0000;

   // Advertisement / partner ability fields
   localparam int ADV_NP     = 15;
   localparam int ADV_RF     = 13;
   localparam int ADV_ABL_LO = 5;
   localparam logic [15:0] ADV_WR_MASK = 16'hA1E0;
   localparam logic [15:0] ADV_RST     = 16'h0001;
   localparam logic [15:0] LPA_PD100   = 16'h0081;
   localparam logic [15:0] LPA_PD10    = 16'h0021;

   // Fixed status bits: 100FD,100HD,10FD,10HD, preamble supp, neg able, ext cap
   localparam logic [15:0] STAT_FIXED = 16'h7849;
   localparam int STAT_DONE = 5;
   localparam int STAT_RF   = 4;
   localparam int STAT_LINK = 2;

   // Expansion register fields
   localparam int EXP_PDF  = 4;
   localparam int EXP_LPNP = 3;
   localparam int EXP_NP   = 2;
   localparam int EXP_PRX  = 1;
   localparam int EXP_LPAB = 0;

   // Result status fields
   localparam int PHY_DONE = 4;
   localparam int PHY_LOOP = 3;
   localparam int PHY_DUP  = 2;
   localparam int PHY_SPD  = 1;
   localparam int PHY_LINK = 0;

   // Timing
   localparam int CLK_HZ     = 40_000_000;
   localparam int BREAK_MS   = 1500;
   localparam int CYC_PER_MS = CLK_HZ / 1000;

   // Negotiation states, Gray along forced->negot->done->break
   typedef enum logic [1:0] {
      ST_FORCED = 2'b00,
      ST_NEGOT  = 2'b01,
      ST_DONE   = 2'b11,
      ST_BREAK  = 2'b10
   } ang_state_e;

   // Priority pick over common abilities {100FD,100HD,10FD,10HD}; returns {ok,spd100,full}
   function automatic logic [2:0] resolve(input logic [3:0] c);
      if (c[3]) return 3'h7;
      else if (c[2]) return 3'h6;
      else if (c[1]) return 3'h5;
      else if (c[0]) return 3'h4;
      else return 3'h0;
   endfunction : resolve
endpackage : ang_pkg
`default_nettype wire

// ==== rtl/ang_break_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
module ang_break_timer #(
   parameter int CYC_PER_MS = ang_pkg::CYC_PER_MS,
   parameter int BREAK_MS   = ang_pkg::BREAK_MS
) (
   input  wire logic i_sys_clk,
   input  wire logic i_sys_rst,
   input  wire logic i_start,
   output logic      o_busy,
   output logic      o_done
);
   localparam int PW = $clog2(CYC_PER_MS + 1);
   localparam int MW = $clog2(BREAK_MS + 1);

   generate
      if (CYC_PER_MS < 1 || BREAK_MS < 1) begin : g_chk
         $error("break timer counts must be at least one");
      end
   endgenerate

   logic [PW-1:0] pre_ff;
   logic [MW-1:0] ms_ff;
   logic          busy_ff;
   logic          done_ff;
   logic          ms_tick;

   // Millisecond enable pulse from the prescaler
   assign ms_tick = busy_ff && (pre_ff == PW'(CYC_PER_MS - 1));

   // Prescaler
   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) pre_ff <= '0;
      else if (i_start || ms_tick) pre_ff <= '0;
      else if (busy_ff) pre_ff <= pre_ff + PW'(1);
   end

   // Millisecond counter and completion pulse
   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         ms_ff   <= '0;
         busy_ff <= 1'b0;
         done_ff <= 1'b0;
      end else begin
         done_ff <= 1'b0;
         if (i_start) begin
            ms_ff   <= '0;
            busy_ff <= 1'b1;
         end else if (ms_tick) begin
            if (ms_ff == MW'(BREAK_MS - 1)) begin
               busy_ff <= 1'b0;
               done_ff <= 1'b1;
            end
            ms_ff <= ms_ff + MW'(1);
         end
      end
   end

   assign o_busy = busy_ff;
   assign o_done = done_ff;
endmodule : ang_break_timer
`default_nettype wire

// ==== rtl/ang_autoneg.sv ====
// Chosen here: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Priority: 100FD, 100HD, 10FD, 10HD
// - Mode from advertised AND partner abilities
// - Send advertisement in bursts while negotiating
// - Ability and enable defaults caught at power-up
// - Forced mode: speed bit 13, duplex 8
// - Manual bits ignored while negotiation enabled
// - Result status: complete, duplex, speed bits
// - Ability bits fixed set, T4 clear
// - Status: complete, fault, link, preamble bits
// - Advertise strapped abilities; software may clear abilities
// - Partner register captures every page received while negotiating
// - Parallel detect loads 0081h or 0021h
// - Expansion: fault, partner NP, page, able
// - Local next-page ability reads one
// - Parallel detect uses both receiver links
// - Parallel detect sets mode bit, selector 00001
// - Partner-able clear marks parallel detect outcome
// - Negotiate at reset and on link loss
// - Both links good sets detect fault
// - Restart bit restarts negotiation while negotiating or done, not during break
// - Restart halts pulses for break timer
module ang_autoneg #(
   parameter int CYC_PER_MS = ang_pkg::CYC_PER_MS,
   parameter int BREAK_MS   = ang_pkg::BREAK_MS
) (
   input  wire logic        i_sys_clk,
   input  wire logic        i_sys_rst,
   input  wire logic        i_wb_cyc,
   input  wire logic        i_wb_stb,
   input  wire logic        i_wb_we,
   input  wire logic [7:0]  i_wb_adr,
   input  wire logic [31:0] i_wb_dat,
   input  wire logic [3:0]  i_wb_sel,
   output logic      [31:0] o_wb_dat,
   output logic             o_wb_ack,
   input  wire logic [3:0]  i_strap_adv,
   input  wire logic        i_strap_an_en,
   input  wire logic        i_link10_good,
   input  wire logic        i_link100_good,
   input  wire logic        i_flp_seen,
   input  wire logic        i_page_valid,
   input  wire logic [15:0] i_page_word,
   output logic             o_flp_en,
   output logic      [15:0] o_flp_word,
   output logic             o_break_halt,
   output logic             o_speed_100,
   output logic             o_full_duplex,
   output logic             o_link_up,
   output logic             o_loopback
);
   ang_pkg::ang_state_e state_ff;
   ang_pkg::ang_state_e nxt_state;
   logic        strap_done_ff;
   logic [15:0] ctrl_ff;
   logic [15:0] adv_ff;
   logic [15:0] lpa_ff;
   logic        pdf_ff;
   logic        prx_ff;
   logic        lpab_ff;
   logic        lpnp_ff;
   logic [4:0]  base_ff;
   logic        done_ff;
   logic [2:0]  res_ff;
   logic        ack_ff;
   logic [31:0] rdat_ff;
   logic        access;
   logic        wr_ctrl;
   logic        wr_adv;
   logic        rd_exp;
   logic        restart;
   logic        an_en;
   logic        page_in;
   logic        page_last;
   logic        pd_one;
   logic        pd_bad;
   logic        sel_link;
   logic        link_lost;
   logic        tmr_start;
   logic        tmr_done;
   logic [2:0]  pick;
   logic [15:0] stat_word;
   logic [15:0] exp_word;
   logic [15:0] phys_word;

   // Byte-lane merge of a write into a 16-bit register
   function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd,
                                         input logic [3:0] sel, input logic [15:0] mask);
      logic [15:0] v;
      v = old;
      if (sel[0]) v[7:0] = wd[7:0];
      if (sel[1]) v[15:8] = wd[15:8];
      return (v & mask) | (old & ~mask);
   endfunction : merge

   // Bus access decode; one access per request, answered on the next edge
   assign access  = i_wb_cyc && i_wb_stb && !ack_ff && strap_done_ff;
   assign wr_ctrl = access && i_wb_we && (i_wb_adr == ang_pkg::ADR_CTRL);
   assign wr_adv  = access && i_wb_we && (i_wb_adr == ang_pkg::ADR_ADV);
   assign rd_exp  = access && !i_wb_we && (i_wb_adr == ang_pkg::ADR_EXP);
   assign restart = wr_ctrl && i_wb_sel[1] && i_wb_dat[ang_pkg::CTL_RESTART];
   assign an_en   = ctrl_ff[ang_pkg::CTL_AN_EN];

   // Negotiation events from the line side
   assign page_in   = (state_ff == ang_pkg::ST_NEGOT) && i_page_valid;
   assign page_last = page_in && !i_page_word[ang_pkg::ADV_NP];
   assign pd_one    = (state_ff == ang_pkg::ST_NEGOT) && !i_flp_seen && !i_page_valid
                      && (i_link10_good ^ i_link100_good);
   assign pd_bad    = (state_ff == ang_pkg::ST_NEGOT) && !i_flp_seen
                      && i_link10_good && i_link100_good;
   // Abilities come from the base page; later pages carry messages
   assign pick      = ang_pkg::resolve(adv_ff[8:5] & (lpab_ff ? base_ff[3:0] : i_page_word[8:5]));

   // Link of the operating speed
   assign sel_link  = o_speed_100 ? i_link100_good : i_link10_good;
   assign link_lost = res_ff[2] && !sel_link;

   // Captures strap levels once, the first edge after reset release
   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) strap_done_ff <= 1'b0;
      else strap_done_ff <= 1'b1;
   end

   // Control register
   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         ctrl_ff <= ang_pkg::CTL_RST;
      end else if (!strap_done_ff) begin
         ctrl_ff[ang_pkg::CTL_AN_EN] <= i_strap_an_en;
      end else if (wr_ctrl) begin
         ctrl_ff <= merge(ctrl_ff, i_wb_dat, i_wb_sel, ang_pkg::CTL_WR_MASK);
      end
   end

   // Advertisement register; selector fixed, abilities strapped then writable
   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         adv_ff <= ang_pkg::ADV_RST;
      end else if (!strap_done_ff) begin
         adv_ff[8:5] <= i_strap_adv;
      end else if (wr_adv) begin
         adv_ff <= merge(adv_ff, i_wb_dat, i_wb_sel, ang_pkg::ADV_WR_MASK);
      end
   end

   // Partner ability register
   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         lpa_ff <= '0;
      end else if (page_in) begin
         lpa_ff <= i_page_word;
      end else if (pd_one) begin
         lpa_ff <= i_link100_good ? ang_pkg::LPA_PD100 : ang_pkg::LPA_PD10;
      end
   end

   // Expansion flags; page and fault clear on read, a new event wins
   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         pdf_ff  <= 1'b0;
         prx_ff  <= 1'b0;
         lpab_ff <= 1'b0;
         lpnp_ff <= 1'b0;
         base_ff <= '0;
      end else begin
         if (pd_bad) pdf_ff <= 1'b1;
         else if (rd_exp) pdf_ff <= 1'b0;
         if (page_in) prx_ff <= 1'b1;
         else if (rd_exp) prx_ff <= 1'b0;
         // Base page of each negotiation sets partner NP, fault and abilities
         if (page_in) begin
            lpab_ff <= 1'b1;
            if (!lpab_ff) begin
               lpnp_ff <= i_page_word[ang_pkg::ADV_NP];
               base_ff <= {i_page_word[ang_pkg::ADV_RF], i_page_word[8:5]};
            end
         end else if (pd_one || (nxt_state == ang_pkg::ST_NEGOT && state_ff != ang_pkg::ST_NEGOT)) begin
            lpab_ff <= 1'b0;
            lpnp_ff <= 1'b0;
         end
      end
   end

   // State register
   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) state_ff <= ang_pkg::ST_FORCED;
      else state_ff <= nxt_state;
   end

   // Next state and break timer start
   always_comb begin
      nxt_state = state_ff;
      tmr_start = 1'b0;
      case (state_ff)
         ang_pkg::ST_FORCED: begin
            if (an_en && strap_done_ff) nxt_state = ang_pkg::ST_NEGOT;
         end
         ang_pkg::ST_NEGOT: begin
            if (!an_en) nxt_state = ang_pkg::ST_FORCED;
            else if (restart) begin
               nxt_state = ang_pkg::ST_BREAK;
               tmr_start = 1'b1;
            end else if (page_last || pd_one) nxt_state = ang_pkg::ST_DONE;
         end
         ang_pkg::ST_DONE: begin
            if (!an_en) nxt_state = ang_pkg::ST_FORCED;
            else if (restart) begin
               nxt_state = ang_pkg::ST_BREAK;
               tmr_start = 1'b1;
            end else if (link_lost) nxt_state = ang_pkg::ST_NEGOT;
         end
         ang_pkg::ST_BREAK: begin
            if (!an_en) nxt_state = ang_pkg::ST_FORCED;
            else if (tmr_done) nxt_state = ang_pkg::ST_NEGOT;
         end
         default: nxt_state = ang_pkg::ST_FORCED;
      endcase
   end

   // Resolved mode and completion
   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         res_ff  <= '0;
         done_ff <= 1'b0;
      end else if (nxt_state != ang_pkg::ST_DONE) begin
         res_ff  <= '0;
         done_ff <= 1'b0;
      end else if (state_ff == ang_pkg::ST_NEGOT) begin
         done_ff <= 1'b1;
         if (page_last) res_ff <= pick;
         else res_ff <= {1'b1, i_link100_good, 1'b0};
      end
   end

   // Break timer
   ang_break_timer #(
      .CYC_PER_MS (CYC_PER_MS),
      .BREAK_MS   (BREAK_MS)
   ) u_break (
      .i_sys_clk (i_sys_clk),
      .i_sys_rst (i_sys_rst),
      .i_start   (tmr_start),
      .o_busy    (),
      .o_done    (tmr_done)
   );

   // Operating mode: manual bits only when negotiation is off
   always_comb begin
      if (state_ff == ang_pkg::ST_FORCED) begin
         o_speed_100   = ctrl_ff[ang_pkg::CTL_SPEED];
         o_full_duplex = ctrl_ff[ang_pkg::CTL_DUPLEX];
      end else begin
         o_speed_100   = res_ff[1];
         o_full_duplex = res_ff[0];
      end
   end

   // Valid link needs a mode and a good receiver at its speed
   assign o_link_up    = ((state_ff == ang_pkg::ST_FORCED) || res_ff[2]) && sel_link;
   assign o_flp_en     = (state_ff == ang_pkg::ST_NEGOT);
   assign o_flp_word   = adv_ff;
   assign o_break_halt = (state_ff == ang_pkg::ST_BREAK);
   assign o_loopback   = ctrl_ff[ang_pkg::CTL_LOOP];

   // Status words
   always_comb begin
      stat_word = ang_pkg::STAT_FIXED;
      stat_word[ang_pkg::STAT_DONE] = done_ff;
      stat_word[ang_pkg::STAT_RF]   = done_ff && lpab_ff && base_ff[4];
      stat_word[ang_pkg::STAT_LINK] = o_link_up;
      exp_word = '0;
      exp_word[ang_pkg::EXP_PDF]  = pdf_ff;
      exp_word[ang_pkg::EXP_LPNP] = lpnp_ff;
      exp_word[ang_pkg::EXP_NP]   = 1'b1;
      exp_word[ang_pkg::EXP_PRX]  = prx_ff;
      exp_word[ang_pkg::EXP_LPAB] = lpab_ff;
      phys_word = '0;
      phys_word[ang_pkg::PHY_DONE] = done_ff;
      phys_word[ang_pkg::PHY_LOOP] = o_loopback;
      phys_word[ang_pkg::PHY_DUP]  = o_full_duplex;
      phys_word[ang_pkg::PHY_SPD]  = o_speed_100;
      phys_word[ang_pkg::PHY_LINK] = o_link_up;
   end

   // Bus answer: ack and read data one edge after the request; unmapped reads zero
   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         ack_ff  <= 1'b0;
         rdat_ff <= '0;
      end else begin
         ack_ff <= access;
         if (access && !i_wb_we) begin
            case (i_wb_adr)
               ang_pkg::ADR_CTRL: rdat_ff <= {16'h0000, ctrl_ff};
               ang_pkg::ADR_STAT: rdat_ff <= {16'h0000, stat_word};
               ang_pkg::ADR_ADV:  rdat_ff <= {16'h0000, adv_ff};
               ang_pkg::ADR_LPA:  rdat_ff <= {16'h0000, lpa_ff};
               ang_pkg::ADR_EXP:  rdat_ff <= {16'h0000, exp_word};
               ang_pkg::ADR_PHYS: rdat_ff <= {16'h0000, phys_word};
               default:           rdat_ff <= '0;
            endcase
         end
      end
   end

   assign o_wb_ack = ack_ff;
   assign o_wb_dat = rdat_ff;
endmodule : ang_autoneg
`default_nettype wire

// ==== tb/ang_autoneg_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module ang_autoneg_monitor #(
   parameter int CYC_PER_MS = 4,
   parameter int BREAK_MS   = 3
) (
   input wire logic        i_sys_clk,
   input wire logic        i_sys_rst,
   input wire logic        i_wb_cyc,
   input wire logic        i_wb_stb,
   input wire logic        i_wb_we,
   input wire logic [7:0]  i_wb_adr,
   input wire logic [31:0] i_wb_dat,
   input wire logic [3:0]  i_wb_sel,
   input wire logic        o_wb_ack,
   input wire logic        i_link10_good,
   input wire logic        i_link100_good,
   input wire logic        i_flp_seen,
   input wire logic        i_page_valid,
   input wire logic [15:0] i_page_word,
   input wire logic        o_flp_en,
   input wire logic [15:0] o_flp_word,
   input wire logic        o_break_halt,
   input wire logic        o_speed_100,
   input wire logic        o_full_duplex,
   input wire logic        o_link_up
);
   localparam int HMAX = CYC_PER_MS * BREAK_MS + 4;
   logic       idle;
   logic       pd_ok;
   logic [3:0] cm_ff;
   logic       got_ff;
   int         halt_cnt_ff;
   // Quiet bus and no page: the only time parallel detect is checked
   assign idle = !(i_wb_cyc && i_wb_stb) && !i_page_valid && !i_flp_seen && o_flp_en;
   assign pd_ok = i_wb_cyc && i_wb_stb && i_wb_we && !o_wb_ack && i_wb_sel[1] && o_flp_en;
   // Common abilities of the base page of this negotiation, and length of the current break
   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         cm_ff  <= 4'h0;
         got_ff <= 1'b0;
      end else if (!o_flp_en) begin
         got_ff <= 1'b0;
      end else if (i_page_valid && !got_ff) begin
         cm_ff  <= o_flp_word[8:5] & i_page_word[8:5];
         got_ff <= 1'b1;
      end
   end
   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) halt_cnt_ff <= 0;
      else halt_cnt_ff <= o_break_halt ? halt_cnt_ff + 1 : 0;
   end
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_sys_rst);
   AST_ACK_ONE: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack held too long");
   AST_ACK_TIME: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack) else $error("ack late");
   AST_HALT_EXCL: assert property (o_break_halt |-> !o_flp_en) else $error("bursts during break");
   AST_RESTART: assert property (pd_ok && i_wb_adr == ang_pkg::ADR_CTRL && i_wb_dat[9] && i_wb_dat[12]
      |=> o_break_halt && !o_flp_en) else $error("restart missed");
   AST_HALT_LEN: assert property (halt_cnt_ff <= HMAX) else $error("break too long");
   AST_PD_ONE: assert property (idle && (i_link10_good != i_link100_good)
      |=> !o_flp_en && o_speed_100 == $past(i_link100_good) && !o_full_duplex) else $error("detect wrong");
   AST_PD_FAULT: assert property (idle && i_link10_good && i_link100_good |=> o_flp_en)
      else $error("detect fault ignored");
   AST_RESOLVE: assert property (o_flp_en && !(i_wb_cyc && i_wb_stb) && i_page_valid && !i_page_word[15]
      |-> ##[1:2] (!o_flp_en && (cm_ff == 4'h0 ? !o_link_up : (o_speed_100 == (cm_ff[3] | cm_ff[2])
      && o_full_duplex == (cm_ff[3] | (!cm_ff[2] & cm_ff[1])))))) else $error("resolution wrong");
   CV_BREAK: cover property ($rose(o_break_halt));
   CV_PAGE: cover property (o_flp_en && i_page_valid);
   CV_NEXT: cover property (o_flp_en && i_page_valid && i_page_word[15]);
   CV_PD: cover property (idle && i_link100_good && !i_link10_good);
endmodule : ang_autoneg_monitor
`default_nettype wire

// ==== tb/ang_link_partner.sv ====
`timescale 1ns/1ps
`default_nettype none
module ang_link_partner (
   input  wire logic        i_sys_clk,
   output logic             o_link10,
   output logic             o_link100,
   output logic             o_flp,
   output logic             o_page_valid,
   output logic      [15:0] o_page_word
);
   // Cable unplugged, no bursts at start
   initial begin
      o_link10 = 1'b0;
      o_link100 = 1'b0;
      o_flp = 1'b0;
      o_page_valid = 1'b0;
      o_page_word = 16'hFFFF;
   end
   // Link signals as the two receivers would report them
   task automatic set_links(input logic l10, input logic l100, input logic flp);
      @(posedge i_sys_clk);
      o_link10 <= l10;
      o_link100 <= l100;
      o_flp <= flp;
   endtask : set_links
   // One received code word; the word goes stale right after its pulse
   task automatic send_page(input logic [15:0] w);
      @(posedge i_sys_clk);
      o_page_valid <= 1'b1;
      o_page_word <= w;
      @(posedge i_sys_clk);
      o_page_valid <= 1'b0;
      o_page_word <= ~w;
   endtask : send_page
endmodule : ang_link_partner
`default_nettype wire

// ==== tb/tb_ang_autoneg.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_ang_autoneg;
   localparam int PMS = 4;
   localparam int PBR = 3;
   logic        i_sys_clk = 1'b0;
   logic        i_sys_rst = 1'b1;
   logic        cyc = 1'b0;
   logic        stb = 1'b0;
   logic        we = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [31:0] wdat = 32'h0;
   logic [3:0]  sel = 4'h0;
   logic [3:0]  strap_adv = 4'hF;
   logic        strap_en = 1'b1;
   logic [31:0] rdat;
   logic        ack, l10, l100, flp, pv, flp_en, halt, spd, fdx, lnk, lpb, rf, np;
   logic [15:0] pw, flp_word, q, w, e;
   logic [3:0]  adv, ab;
   logic [1:0]  mm;
   int          failures = 0;
   int          compares = 0;
   int          seed;
   // Free-running 40 MHz clock
   always #12.5 i_sys_clk = ~i_sys_clk;
   ang_autoneg #(.CYC_PER_MS(PMS), .BREAK_MS(PBR)) u_ang_autoneg (
      .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
      .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(sel), .o_wb_dat(rdat), .o_wb_ack(ack),
      .i_strap_adv(strap_adv), .i_strap_an_en(strap_en), .i_link10_good(l10), .i_link100_good(l100),
      .i_flp_seen(flp), .i_page_valid(pv), .i_page_word(pw), .o_flp_en(flp_en), .o_flp_word(flp_word),
      .o_break_halt(halt), .o_speed_100(spd), .o_full_duplex(fdx), .o_link_up(lnk), .o_loopback(lpb));
   ang_link_partner u_ang_link_partner (.i_sys_clk(i_sys_clk), .o_link10(l10), .o_link100(l100),
      .o_flp(flp), .o_page_valid(pv), .o_page_word(pw));
   task automatic tally_and_finish;
      if (failures == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : tally_and_finish
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   // Classic single cycle, held until ack is sampled
   task automatic wb(input logic wr, input logic [7:0] a, input logic [15:0] d);
      int n;
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= wr;
      adr <= a;
      wdat <= {16'h0000, d};
      sel <= 4'h3;
      do begin
         @(posedge i_sys_clk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      q = rdat[15:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(posedge i_sys_clk);
      if (n >= 50) begin
         failures++;
         tally_and_finish();
      end
   endtask : wb
   task automatic chk_reg(input logic [7:0] a, input logic [15:0] m, input logic [15:0] x);
      wb(1'b0, a, 16'h0000);
      chk($sformatf("reg %h", a), x & m, q & m);
   endtask : chk_reg
   // Restart and sit out the break wait
   task automatic restart(input logic [15:0] d);
      int n;
      n = 0;
      wb(1'b1, ang_pkg::ADR_CTRL, d);
      chk("o_break_halt", 16'h0001, {15'h0, halt});
      while (halt !== 1'b0 && n < 100) begin
         @(posedge i_sys_clk);
         n++;
      end
      if (n >= 100) begin
         failures++;
         tally_and_finish();
      end
      chk("break length", 16'h0001, {15'h0, n >= PMS * PBR - 4 && n <= PMS * PBR + 4});
   endtask : restart
   // Result register expected from the common abilities
   function automatic logic [15:0] exp_phys(input logic [3:0] c);
      return {11'h000, 1'b1, 1'b0, c[3] | (~c[2] & c[1]), c[3] | c[2], c != 4'h0};
   endfunction : exp_phys
   initial begin
      seed = $urandom(60822);
      strap_adv <= 4'($urandom_range(15, 1));
      repeat (8) @(posedge i_sys_clk);
      i_sys_rst <= 1'b0;
      repeat (2) @(posedge i_sys_clk);
      chk_reg(ang_pkg::ADR_CTRL, 16'h1000, 16'h1000);
      chk_reg(ang_pkg::ADR_ADV, 16'hA1FF, {7'h00, strap_adv, 5'h01});
      chk_reg(ang_pkg::ADR_STAT, 16'hF849, 16'h7849);
      chk_reg(ang_pkg::ADR_EXP, 16'h0004, 16'h0004);
      chk_reg(8'hA0, 16'hFFFF, 16'h0000);
      u_ang_link_partner.set_links(1'b1, 1'b1, 1'b1);
      for (int i = 0; i < 6; i++) begin
         adv = (i == 5) ? 4'hF : 4'($urandom);
         ab = (i == 5) ? 4'hF : 4'($urandom);
         rf = 1'($urandom);
         np = (i == 5) ? 1'b1 : 1'($urandom);
         w = {np, 1'b0, rf, 4'h0, ab, 5'h01};
         wb(1'b1, ang_pkg::ADR_ADV, {7'h00, adv, 5'h01});
         restart(16'h1200 | (16'($urandom) & 16'h2100));
         chk("o_flp_en", 16'h0001, {15'h0, flp_en});
         chk("o_flp_word", {7'h00, adv, 5'h01}, flp_word);
         // Base page with next-page flag, then one message page ends the exchange
         if (np) begin
            u_ang_link_partner.send_page(w);
            w = {1'b0, 15'($urandom)};
         end
         u_ang_link_partner.send_page(w);
         repeat (3) @(posedge i_sys_clk);
         e = exp_phys(adv & ab);
         chk_reg(ang_pkg::ADR_PHYS, (adv & ab) == 4'h0 ? 16'h0019 : 16'h001F, e);
         chk_reg(ang_pkg::ADR_STAT, 16'h0034, {10'h0, 1'b1, rf, 1'b0, e[0], 2'b00});
         chk_reg(ang_pkg::ADR_LPA, 16'hFFFF, w);
         chk_reg(ang_pkg::ADR_EXP, 16'h000F, {12'h000, np, 3'b111});
      end
      u_ang_link_partner.set_links(1'b1, 1'b0, 1'b1);
      repeat (2) @(posedge i_sys_clk);
      chk("o_flp_en", 16'h0001, {15'h0, flp_en});
      for (int k = 0; k < 3; k++) begin
         u_ang_link_partner.set_links(k != 1, k != 0, 1'b0);
         restart(16'h1200);
         repeat (3) @(posedge i_sys_clk);
         if (k < 2) begin
            chk_reg(ang_pkg::ADR_LPA, 16'hFFFF, k ? 16'h0081 : 16'h0021);
            chk_reg(ang_pkg::ADR_STAT, 16'h0020, 16'h0020);
            chk_reg(ang_pkg::ADR_EXP, 16'h0001, 16'h0000);
            chk_reg(ang_pkg::ADR_PHYS, 16'h0007, {13'h0, 1'b0, 1'(k), 1'b1});
         end else begin
            chk_reg(ang_pkg::ADR_EXP, 16'h0010, 16'h0010);
            chk("o_flp_en", 16'h0001, {15'h0, flp_en});
         end
      end
      for (int m = 0; m < 4; m++) begin
         mm = 2'(m);
         w = {1'b0, mm[0], mm[1], 4'h0, mm[0], 8'h00};
         wb(1'b1, ang_pkg::ADR_CTRL, w);
         chk("o_speed_100", {15'h0, mm[1]}, {15'h0, spd});
         chk("o_full_duplex", {15'h0, mm[0]}, {15'h0, fdx});
         chk("o_loopback", {15'h0, mm[0]}, {15'h0, lpb});
         chk_reg(ang_pkg::ADR_PHYS, 16'h000E, {12'h000, mm[0], mm[0], mm[1], 1'b0});
         chk_reg(ang_pkg::ADR_CTRL, 16'h7100, w);
      end
      // Second power-up with negotiation strapped off
      strap_en <= 1'b0;
      strap_adv <= 4'($urandom);
      i_sys_rst <= 1'b1;
      repeat (8) @(posedge i_sys_clk);
      i_sys_rst <= 1'b0;
      repeat (2) @(posedge i_sys_clk);
      chk_reg(ang_pkg::ADR_CTRL, 16'h1000, 16'h0000);
      chk_reg(ang_pkg::ADR_ADV, 16'hA1FF, {7'h00, strap_adv, 5'h01});
      chk("o_flp_en", 16'h0000, {15'h0, flp_en});
      tally_and_finish();
   end
endmodule : tb_ang_autoneg
bind ang_autoneg ang_autoneg_monitor #(.CYC_PER_MS(CYC_PER_MS), .BREAK_MS(BREAK_MS)) u_ang_autoneg_monitor (.*);
`default_nettype wire
